// [hw/pudc_consts.vh]
`ifndef PUDC_CONSTS_VH
`define PUDC_CONSTS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define PUDC_OFS_DEV_CAP        8'h94
`define PUDC_OFS_DEV_CTRL       8'h98

// ****************************************
// Device capabilities field layout
// ****************************************
`define PUDC_CAP_SCALE_HI       27
`define PUDC_CAP_SCALE_LO       26
`define PUDC_CAP_VALUE_HI       25
`define PUDC_CAP_VALUE_LO       18
`define PUDC_CAP_ROLE_ERR_BIT   15
`define PUDC_CAP_EXT_TAG_BIT    5
`define PUDC_CAP_PHANTOM_HI     4
`define PUDC_CAP_PHANTOM_LO     3
`define PUDC_CAP_MAX_PLD_HI     2
`define PUDC_CAP_MAX_PLD_LO     0
`define PUDC_ROLE_ERR_VAL       1'h1
`define PUDC_EXT_TAG_VAL        1'h0
`define PUDC_PHANTOM_VAL        2'h0
`define PUDC_MAX_PLD_VAL        3'h1

// ****************************************
// Device control field layout and reset
// ****************************************
`define PUDC_CTRL_RSVD_BIT      15
`define PUDC_CTRL_RD_REQ_HI     14
`define PUDC_CTRL_RD_REQ_LO     12
`define PUDC_CTRL_RD_REQ_BYTE   1
`define PUDC_CTRL_RESET         16'h2000
`define PUDC_RD_REQ_RESET       3'h2
`define PUDC_RD_REQ_MAX_CODE    3'h5

// ****************************************
// Power-limit message
// ****************************************
`define PUDC_MSG_SET_PWR_LIMIT  8'h50
`define PUDC_MSG_VALUE_HI       7
`define PUDC_MSG_VALUE_LO       0
`define PUDC_MSG_SCALE_HI       9
`define PUDC_MSG_SCALE_LO       8
`define PUDC_SCALE_1X           2'h0
`define PUDC_SCALE_0P1X         2'h1
`define PUDC_SCALE_0P01X        2'h2
`define PUDC_SCALE_0P001X       2'h3
`define PUDC_MW_1X              18'h003e8
`define PUDC_MW_0P1X            18'h00064
`define PUDC_MW_0P01X           18'h0000a
`define PUDC_MW_0P001X          18'h00001

// ****************************************
// Read request sizing
// ****************************************
`define PUDC_RD_REQ_MIN_BYTES   14'h0080

`endif

// [hw/pudc_power_calc.v]
`timescale 1ns/1ns
`include "pudc_consts.vh"

module pudc_power_calc (
    // Clock and reset
    input  wire        clock,
    input  wire        srst,
    // Captured fields
    input  wire [7:0]  limitValue,
    input  wire [1:0]  limitScale,
    // Power limit in milliwatts
    output reg  [17:0] limitMilliwatt
);

    reg [17:0] multNxt;

    // ****************************************
    // Scale code to milliwatt multiplier
    // ****************************************
    always @* begin
        case (limitScale)
            `PUDC_SCALE_1X:     multNxt = `PUDC_MW_1X;
            `PUDC_SCALE_0P1X:   multNxt = `PUDC_MW_0P1X;
            `PUDC_SCALE_0P01X:  multNxt = `PUDC_MW_0P01X;
            `PUDC_SCALE_0P001X: multNxt = `PUDC_MW_0P001X;
            default:            multNxt = `PUDC_MW_1X;
        endcase
    end

    always @(posedge clock) begin
        if (srst) begin
            limitMilliwatt <= 18'h00000;
        end else begin
            limitMilliwatt <= multNxt * {10'h000, limitValue};
        end
    end

endmodule // pudc_power_calc

// [hw/pudc_read_sizer.v]
`timescale 1ns/1ns
`include "pudc_consts.vh"

module pudc_read_sizer (
    // Clock and reset
    input  wire        clock,
    input  wire        srst,
    // Limits
    input  wire [13:0] maxReadBytes,
    input  wire [7:0]  cacheLineSize,
    // Request in
    input  wire        reqValid,
    input  wire [13:0] reqBytes,
    // Fetch size out
    output reg         fetchValid,
    output reg  [13:0] fetchBytes
);

    wire [13:0] lineBytes = {4'h0, cacheLineSize, 2'h0};
    wire [13:0] lineMask  = lineBytes - 14'h0001;
    wire [13:0] rounded   = (cacheLineSize == 8'h00) ? reqBytes
                          : ((reqBytes + lineMask) & ~lineMask);

    // ****************************************
    // Round to cache lines, cap at the maximum
    // ****************************************
    always @(posedge clock) begin
        if (srst) begin
            fetchValid <= 1'b0;
            fetchBytes <= 14'h0000;
        end else begin
            fetchValid <= reqValid;
            if (reqValid) begin
                fetchBytes <= (rounded > maxReadBytes) ? maxReadBytes : rounded;
            end
        end
    end

endmodule // pudc_read_sizer

// [hw/pudc_dev_regs.v]
// Overview of operation
// - Power message value bits land in cap 25:18
// - Power message scale bits land in cap 27:26
// - Reported limit is value times scale multiplier
// - Captured fields change only by message
// - Capability bits 17:16 and 14:6 read zero
// - Capability bit 15 reads one
// - Capability bit 5 reads zero
// - Capability bits 4:3 read 00b
// - Capability bits 2:0 read 001b
// - Control bit 15 reads zero
// - Control 14:12 sets max read request size
// - Fetch size uses cache line, capped maximum
`timescale 1ns/1ns
`include "pudc_consts.vh"

module pudc_dev_regs (
    // Clock and reset
    input  wire        clock,
    input  wire        srst,
    // Configuration access
    input  wire        cfgRead,
    input  wire        cfgWrite,
    input  wire [7:0]  cfgAddr,
    input  wire [3:0]  cfgByteEn,
    input  wire [31:0] cfgWrData,
    output reg         cfgRdValid,
    output reg  [31:0] cfgRdData,
    // Received message
    input  wire        msgValid,
    input  wire [7:0]  msgCode,
    input  wire [9:0]  msgPayload,
    // Power limit out
    output wire [17:0] slotPowerMilliwatt,
    // Read request sizing
    input  wire [7:0]  cacheLineSize,
    input  wire        reqValid,
    input  wire [13:0] reqBytes,
    output wire        fetchValid,
    output wire [13:0] fetchBytes,
    output reg  [13:0] maxReadReqBytes
);

    // ****************************************
    // State
    // ****************************************
    reg  [7:0]  powerValue_r;
    reg  [1:0]  powerScale_r;
    reg  [2:0]  maxReadReqSize_r;
    reg  [2:0]  maxReadReqSize_nxt;
    reg  [31:0] capWord;
    reg  [31:0] ctrlWord;
    reg  [31:0] rdData_nxt;

    wire        hitCap  = (cfgAddr[7:2] == `PUDC_OFS_DEV_CAP >> 2);
    wire        hitCtrl = (cfgAddr[7:2] == `PUDC_OFS_DEV_CTRL >> 2);
    wire        msgSetPower = msgValid && (msgCode == `PUDC_MSG_SET_PWR_LIMIT);

    // Code to byte count, reserved codes fall back to the smallest
    function [13:0] rdReqBytes;
        input [2:0] code;
        begin
            if (code > `PUDC_RD_REQ_MAX_CODE) begin
                rdReqBytes = `PUDC_RD_REQ_MIN_BYTES;
            end else begin
                rdReqBytes = `PUDC_RD_REQ_MIN_BYTES << code;
            end
        end
    endfunction

    // ****************************************
    // Captured power limit
    // ****************************************
    always @(posedge clock) begin
        if (srst) begin
            powerValue_r <= 8'h00;
            powerScale_r <= 2'h0;
        end else if (msgSetPower) begin
            // Config writes never reach these fields
            powerValue_r <= msgPayload[`PUDC_MSG_VALUE_HI:`PUDC_MSG_VALUE_LO];
            powerScale_r <= msgPayload[`PUDC_MSG_SCALE_HI:`PUDC_MSG_SCALE_LO];
        end
    end

    // ****************************************
    // Device control write
    // ****************************************
    always @* begin
        maxReadReqSize_nxt = maxReadReqSize_r;
        if (cfgWrite && hitCtrl && cfgByteEn[`PUDC_CTRL_RD_REQ_BYTE]) begin
            maxReadReqSize_nxt = cfgWrData[`PUDC_CTRL_RD_REQ_HI:`PUDC_CTRL_RD_REQ_LO];
        end
    end

    always @(posedge clock) begin
        if (srst) begin
            maxReadReqSize_r <= `PUDC_RD_REQ_RESET;
            maxReadReqBytes  <= rdReqBytes(`PUDC_RD_REQ_RESET);
        end else begin
            maxReadReqSize_r <= maxReadReqSize_nxt;
            maxReadReqBytes  <= rdReqBytes(maxReadReqSize_nxt);
        end
    end

    // ****************************************
    // Read words
    // ****************************************
    always @* begin
        capWord = 32'h00000000;
        capWord[`PUDC_CAP_SCALE_HI:`PUDC_CAP_SCALE_LO] = powerScale_r;
        capWord[`PUDC_CAP_VALUE_HI:`PUDC_CAP_VALUE_LO] = powerValue_r;
        capWord[`PUDC_CAP_ROLE_ERR_BIT] = `PUDC_ROLE_ERR_VAL;
        capWord[`PUDC_CAP_EXT_TAG_BIT] = `PUDC_EXT_TAG_VAL;
        capWord[`PUDC_CAP_PHANTOM_HI:`PUDC_CAP_PHANTOM_LO] = `PUDC_PHANTOM_VAL;
        capWord[`PUDC_CAP_MAX_PLD_HI:`PUDC_CAP_MAX_PLD_LO] = `PUDC_MAX_PLD_VAL;
        ctrlWord = 32'h00000000;
        ctrlWord[`PUDC_CTRL_RSVD_BIT] = 1'b0;
        ctrlWord[`PUDC_CTRL_RD_REQ_HI:`PUDC_CTRL_RD_REQ_LO] = maxReadReqSize_r;
        if (hitCap) begin
            rdData_nxt = capWord;
        end else if (hitCtrl) begin
            rdData_nxt = ctrlWord;
        end else begin
            rdData_nxt = 32'h00000000;
        end
    end

    always @(posedge clock) begin
        if (srst) begin
            cfgRdValid <= 1'b0;
            cfgRdData  <= 32'h00000000;
        end else begin
            cfgRdValid <= cfgRead;
            if (cfgRead) begin
                cfgRdData <= rdData_nxt;
            end
        end
    end

    // ****************************************
    // Helpers
    // ****************************************
    pudc_power_calc uPower (
        .clock          (clock),
        .srst           (srst),
        .limitValue     (powerValue_r),
        .limitScale     (powerScale_r),
        .limitMilliwatt (slotPowerMilliwatt)
    );

    pudc_read_sizer uSizer (
        .clock          (clock),
        .srst           (srst),
        .maxReadBytes   (maxReadReqBytes),
        .cacheLineSize  (cacheLineSize),
        .reqValid       (reqValid),
        .reqBytes       (reqBytes),
        .fetchValid     (fetchValid),
        .fetchBytes     (fetchBytes)
    );

endmodule // pudc_dev_regs

// [tb/pudc_checker.sv]
`timescale 1ns/1ns
`include "pudc_consts.vh"
module pudc_checker (
    // Clock and reset
    input wire        clock,
    input wire        srst,
    // Config access
    input wire        cfgRead,
    input wire        cfgWrite,
    input wire [7:0]  cfgAddr,
    input wire [3:0]  cfgByteEn,
    input wire [31:0] cfgWrData,
    input wire [31:0] cfgRdData,
    // Message and outputs
    input wire        msgValid,
    input wire [7:0]  msgCode,
    input wire [9:0]  msgPayload,
    input wire [17:0] slotPowerMilliwatt,
    input wire        reqValid,
    input wire        fetchValid,
    input wire [13:0] fetchBytes,
    input wire [13:0] maxReadReqBytes
);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    wire capRd = cfgRead && cfgAddr[7:2] == 6'h25;
    wire ctlRd = cfgRead && cfgAddr[7:2] == 6'h26;
    wire ctlWr = cfgWrite && cfgAddr[7:2] == 6'h26 && cfgByteEn[1];
    sequence pwrMsg;
        msgValid && msgCode == `PUDC_MSG_SET_PWR_LIMIT;
    endsequence
    function automatic [17:0] pw(input [9:0] p);
        pw = p[7:0] * (p[9:8] == 2'h0 ? `PUDC_MW_1X : p[9:8] == 2'h1 ? `PUDC_MW_0P1X :
                       p[9:8] == 2'h2 ? `PUDC_MW_0P01X : `PUDC_MW_0P001X);
    endfunction
    function automatic [13:0] sz(input [31:0] d);
        sz = 14'h0080 << d[14:12];
    endfunction
    cap_rsvd_a: assert property (capRd |=> cfgRdData[17:16] == 2'h0 && cfgRdData[14:6] == 9'h000)
        else $error("cap reserved bits set");
    cap_fixed_a: assert property (capRd |=> {cfgRdData[15], cfgRdData[5:0]} == 7'h41)
        else $error("cap fixed bits wrong");
    ctl_rsvd_a: assert property (ctlRd |=> cfgRdData[31:15] == 17'h0)
        else $error("ctrl reserved bits set");
    msg_cap_a: assert property (pwrMsg ##1 !msgValid [*2] ##0 capRd
        |=> cfgRdData[27:18] == $past(msgPayload, 3))
        else $error("captured fields wrong");
    power_calc_a: assert property (pwrMsg ##1 !msgValid [*3]
        |-> slotPowerMilliwatt == pw($past(msgPayload, 3)))
        else $error("power limit wrong");
    power_hold_a: assert property (!msgValid [*3] |-> $stable(slotPowerMilliwatt))
        else $error("power limit changed");
    rd_req_write_a: assert property (ctlWr && cfgWrData[14:12] <= 3'h5 ##1 !ctlWr
        |=> maxReadReqBytes == sz($past(cfgWrData, 2)))
        else $error("read request size wrong");
    rd_req_keep_a: assert property (!ctlWr [*3] |-> $stable(maxReadReqBytes))
        else $error("read request size changed");
    fetch_cap_a: assert property (reqValid |=> fetchValid && fetchBytes <= maxReadReqBytes)
        else $error("fetch above maximum");
endmodule // pudc_checker

bind pudc_dev_regs pudc_checker u_chk (
    .clock              (clock),
    .srst               (srst),
    .cfgRead            (cfgRead),
    .cfgWrite           (cfgWrite),
    .cfgAddr            (cfgAddr),
    .cfgByteEn          (cfgByteEn),
    .cfgWrData          (cfgWrData),
    .cfgRdData          (cfgRdData),
    .msgValid           (msgValid),
    .msgCode            (msgCode),
    .msgPayload         (msgPayload),
    .slotPowerMilliwatt (slotPowerMilliwatt),
    .reqValid           (reqValid),
    .fetchValid         (fetchValid),
    .fetchBytes         (fetchBytes),
    .maxReadReqBytes    (maxReadReqBytes)
);

// [tb/pudc_host_model.sv]
`timescale 1ns/1ns
module pudc_host_model (
    // Clock
    input  wire       clock,
    // Message out
    output reg        msgValid,
    output reg  [7:0] msgCode,
    output reg  [9:0] msgPayload
);
    initial begin
        msgValid = 1'b0;
        msgCode = 8'h00;
        msgPayload = 10'h000;
    end
    // One-cycle message, fields scrambled after
    task send(input [7:0] code, input [9:0] pay);
        begin
            @(posedge clock);
            msgValid <= 1'b1;
            msgCode <= code;
            msgPayload <= pay;
            @(posedge clock);
            msgValid <= 1'b0;
            msgCode <= ~code;
            msgPayload <= ~pay;
        end
    endtask
endmodule // pudc_host_model

// [tb/tb.sv]
`timescale 1ns/1ns
module tb;
    reg         clock = 1'b0;
    reg         srst = 1'b1;
    reg         cfgRead = 1'b0;
    reg         cfgWrite = 1'b0;
    reg  [7:0]  cfgAddr = 8'h00;
    reg  [3:0]  cfgByteEn = 4'h0;
    reg  [31:0] cfgWrData = 32'h0;
    reg  [7:0]  cacheLineSize = 8'h00;
    reg         reqValid = 1'b0;
    reg  [13:0] reqBytes = 14'h0;
    wire        cfgRdValid;
    wire        fetchValid;
    wire        msgValid;
    wire [31:0] cfgRdData;
    wire [7:0]  msgCode;
    wire [9:0]  msgPayload;
    wire [17:0] slotPowerMilliwatt;
    wire [13:0] fetchBytes;
    wire [13:0] maxReadReqBytes;
    reg  [31:0] rdat;
    integer     mismatches = 0;
    integer     checked = 0;
    integer     cyc = 0;
    integer     i;
    always #20 clock = ~clock;
    pudc_dev_regs dut (
        .clock              (clock),
        .srst               (srst),
        .cfgRead            (cfgRead),
        .cfgWrite           (cfgWrite),
        .cfgAddr            (cfgAddr),
        .cfgByteEn          (cfgByteEn),
        .cfgWrData          (cfgWrData),
        .cfgRdValid         (cfgRdValid),
        .cfgRdData          (cfgRdData),
        .msgValid           (msgValid),
        .msgCode            (msgCode),
        .msgPayload         (msgPayload),
        .slotPowerMilliwatt (slotPowerMilliwatt),
        .cacheLineSize      (cacheLineSize),
        .reqValid           (reqValid),
        .reqBytes           (reqBytes),
        .fetchValid         (fetchValid),
        .fetchBytes         (fetchBytes),
        .maxReadReqBytes    (maxReadReqBytes)
    );
    pudc_host_model host (
        .clock              (clock),
        .msgValid           (msgValid),
        .msgCode            (msgCode),
        .msgPayload         (msgPayload)
    );
    task chk(input [127:0] what, input [31:0] exp, input [31:0] got);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("CHECK FAILED %0s exp %h got %h", what, exp, got);
            end
        end
    endtask
    task wr(input [7:0] a, input [3:0] be, input [31:0] d);
        begin
            @(posedge clock);
            cfgWrite <= 1'b1;
            cfgAddr <= a;
            cfgByteEn <= be;
            cfgWrData <= d;
            @(posedge clock);
            cfgWrite <= 1'b0;
        end
    endtask
    task rd(input [7:0] a);
        begin
            @(posedge clock);
            cfgRead <= 1'b1;
            cfgAddr <= a;
            @(posedge clock);
            cfgRead <= 1'b0;
            #1;
            chk("rdvalid", 32'h1, {31'h0, cfgRdValid});
            rdat = cfgRdData;
        end
    endtask
    task fetch(input [7:0] cl, input [13:0] n, input [13:0] exp);
        begin
            @(posedge clock);
            reqValid <= 1'b1;
            reqBytes <= n;
            cacheLineSize <= cl;
            @(posedge clock);
            reqValid <= 1'b0;
            #1;
            chk("fetch", {17'h0, 1'b1, exp}, {17'h0, fetchValid, fetchBytes});
        end
    endtask
    task test_done;
        begin
            $display("checked %0d mismatches %0d", checked, mismatches);
            if (mismatches == 0 && checked > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            mismatches = mismatches + 1;
            test_done;
        end
    end
    initial begin
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        rd(8'h94);
        chk("cap", 32'h00008001, rdat);
        rd(8'h98);
        chk("ctrl", 32'h00002000, rdat);
        chk("rdreq", 32'h200, {18'h0, maxReadReqBytes});
        wr(8'h94, 4'hf, 32'hffffffff);
        rd(8'h94);
        chk("cap ro", 32'h00008001, rdat);
        for (i = 0; i < 6; i = i + 1) begin
            wr(8'h98, 4'hf, 32'hffff8fff | (i << 12));
            rd(8'h98);
            chk("ctrl", i << 12, rdat);
            chk("rdreq", 32'h80 << i, {18'h0, maxReadReqBytes});
        end
        wr(8'h98, 4'hd, 32'h0);
        rd(8'h98);
        chk("ctrl lane", 32'h5000, rdat);
        fetch(8'h10, 14'd100, 14'd128);
        fetch(8'h20, 14'd4000, 14'd4096);
        wr(8'h98, 4'h2, 32'h0);
        fetch(8'h10, 14'd300, 14'd128);
        fetch(8'h00, 14'd100, 14'd100);
        wr(8'h98, 4'h2, 32'h6000);
        rd(8'h98);
        chk("ctrl rsvd code", 32'h6000, rdat);
        chk("rdreq rsvd", 32'h80, {18'h0, maxReadReqBytes});
        rd(8'h9c);
        chk("unmapped", 32'h0, rdat);
        for (i = 0; i < 4; i = i + 1) begin
            host.send(8'h50, {i[1:0], 8'hf0 + i[7:0]});
            rd(8'h94);
            chk("cap msg", {4'h0, i[1:0], 8'hf0 + i[7:0], 18'h08001}, rdat);
            chk("mw", (240 + i) * (10 ** (3 - i)), {14'h0, slotPowerMilliwatt});
        end
        host.send(8'h51, 10'h000);
        rd(8'h94);
        chk("cap code", {4'h0, 2'h3, 8'hf3, 18'h08001}, rdat);
        test_done;
    end
endmodule // tb
